/* File: include/dpc_pkg.sv */
// Constants for the phase-loop control and lock status register bank
package dpc_pkg;

	// ----------------------------------------------------------------
	// Serial port framing
	// ----------------------------------------------------------------
	localparam int         ADDR_W        = 7;
	localparam int         DATA_W        = 8;
	localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
	localparam logic [4:0] SPI_DATA_FRST = 5'h08;
	localparam logic [4:0] SPI_LAST_BIT  = 5'h0F;
	localparam logic [4:0] SPI_DONE      = 5'h10;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_STATUS  = 7'h21;
	localparam logic [6:0] ADDR_POS_CM  = 7'h22;
	localparam logic [6:0] ADDR_NEG_CM  = 7'h23;
	localparam logic [6:0] ADDR_BIAS    = 7'h24;
	localparam logic [6:0] ADDR_DUTY    = 7'h25;
	localparam logic [6:0] ADDR_MAIN    = 7'h26;
	localparam logic [6:0] ADDR_SRCH    = 7'h27;
	localparam logic [6:0] ADDR_LOOP_ST = 7'h2A;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int STAT_SYNC_TRK = 7;
	localparam int STAT_SYNC_LOST_FLAG = 5;
	localparam int STAT_SYNC_LOCKED_FLAG = 4;
	localparam int STAT_RCVR_TRK = 3;
	localparam int STAT_RECEIVER_LOST_FLAG = 1;
	localparam int STAT_RECEIVER_LOCKED_FLAG = 0;
	localparam int CM_DIR        = 4;
	localparam int BIAS_CMP      = 5;
	localparam int BIAS_PD       = 4;
	localparam int DUTY_EN       = 7;
	localparam int MAIN_SLOPE    = 6;
	localparam int MAIN_MODE_LO  = 4;
	localparam int MAIN_RD       = 3;
	localparam int MAIN_GAIN_LO  = 1;
	localparam int MAIN_EN       = 0;
	localparam int SRCH_DEL_LSB  = 7;
	localparam int SRCH_DIR_LO   = 5;
	localparam int LOOP_LST      = 1;
	localparam int LOOP_LCK      = 0;

	// ----------------------------------------------------------------
	// Reset values and writable bits
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO  = 8'h00;
	localparam logic [7:0] RST_MAIN  = 8'h42;
	localparam logic [7:0] MASK_CM   = 8'h1F;
	localparam logic [7:0] MASK_BIAS = 8'h30;
	localparam logic [7:0] MASK_DUTY = 8'h80;
	localparam logic [7:0] MASK_MAIN = 8'h7F;
	localparam logic [7:0] MASK_SRCH = 8'hFF;

	// ----------------------------------------------------------------
	// Operating modes and search directions
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_SRCH_TRACK = 2'b00,
		MODE_SRCH_ONLY  = 2'b01,
		MODE_TRACK_ONLY = 2'b10,
		MODE_RESERVED   = 2'b11
	} dpc_mode_t;

	typedef enum logic [1:0] {
		DIR_DOWN    = 2'b00,
		DIR_UP      = 2'b01,
		DIR_DOWN_UP = 2'b10,
		DIR_RSVD    = 2'b11
	} dpc_dir_t;

endpackage

/* File: hdl/dpc_spi_port.sv */
// Serial configuration port: pin synchronisers and frame shifter
`timescale 1ns/1ps
module dpc_spi_port #(
	parameter int ADDR_W = 7,
	parameter int DATA_W = 8
) (
	// Clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_rstn,
	// Serial pins
	input  wire logic              i_sclk,
	input  wire logic              i_csn,
	input  wire logic              i_sdi,
	output logic                   o_sdo,
	output logic                   o_sdo_oe,
	// Register side
	input  wire logic [DATA_W-1:0] i_rdata,
	output logic                   o_wr,
	output logic [ADDR_W-1:0]      o_addr,
	output logic [DATA_W-1:0]      o_wdata
);

	// Refuse widths the shifter cannot serve
	if (ADDR_W != 7 || DATA_W != 8) begin : g_bad_width
		$error("dpc_spi_port supports only 7-bit address and 8-bit data");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0]  sclk_s_q;
	logic [1:0]  csn_s_q;
	logic [1:0]  sdi_s_q;
	logic [4:0]  cnt_q;
	logic [14:0] sh_q;
	logic        rw_q;
	logic        load_q;
	logic [7:0]  rd_sh_q;

	wire rise      = sclk_s_q[1] & ~sclk_s_q[2];
	wire fall      = ~sclk_s_q[1] & sclk_s_q[2];
	wire active    = ~csn_s_q[1];
	wire data_ph   = (cnt_q >= dpc_pkg::SPI_DATA_FRST) && (cnt_q < dpc_pkg::SPI_DONE);
	wire addr_done = active & rise & (cnt_q == dpc_pkg::SPI_ADDR_LAST);
	wire last_bit  = active & rise & (cnt_q == dpc_pkg::SPI_LAST_BIT);

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sclk_s_q <= 3'h0;
			csn_s_q  <= 2'h3;
			sdi_s_q  <= 2'h0;
		end else begin
			sclk_s_q <= {sclk_s_q[1:0], i_sclk};
			csn_s_q  <= {csn_s_q[0], i_csn};
			sdi_s_q  <= {sdi_s_q[0], i_sdi};
		end
	end

	// ----------------------------------------------------------------
	// Frame shifter
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= 5'h00;
			sh_q  <= 15'h0000;
		end else if (!active) begin
			cnt_q <= 5'h00;
		end else if (rise) begin
			cnt_q <= (cnt_q == dpc_pkg::SPI_DONE) ? cnt_q : cnt_q + 5'h01;
			sh_q  <= {sh_q[13:0], sdi_s_q[1]};
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rw_q   <= 1'b0;
			load_q <= 1'b0;
			o_addr <= '0;
		end else begin
			load_q <= addr_done & sh_q[6];
			if (addr_done) begin
				rw_q   <= sh_q[6];
				o_addr <= {sh_q[5:0], sdi_s_q[1]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Write strobe and read shift-out
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wr    <= 1'b0;
			o_wdata <= '0;
		end else begin
			o_wr <= last_bit & ~rw_q;
			if (last_bit) begin
				o_wdata <= {sh_q[6:0], sdi_s_q[1]};
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_sh_q  <= 8'h00;
			o_sdo    <= 1'b0;
			o_sdo_oe <= 1'b0;
		end else begin
			o_sdo_oe <= active & rw_q & data_ph;
			if (load_q) begin
				rd_sh_q <= i_rdata;
			end else if (active & fall & rw_q & data_ph) begin
				rd_sh_q <= {rd_sh_q[6:0], 1'b0};
				o_sdo   <= rd_sh_q[7];
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	wr_one_pulse_a: assert property (o_wr |=> !o_wr)
		else $error("write strobe longer than one cycle");
	drive_read_only_a: assert property (o_sdo_oe |-> rw_q)
		else $error("output driven during a write frame");

endmodule // dpc_spi_port

/* File: hdl/dpc_regs.sv */
// Phase-loop control and controller lock status register bank
`timescale 1ns/1ps
module dpc_regs (
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	// Serial configuration port
	input  wire logic       i_sclk,
	input  wire logic       i_csn,
	input  wire logic       i_sdi,
	output logic            o_sdo,
	output logic            o_sdo_oe,
	// Controller state
	input  wire logic       i_sync_tracking,
	input  wire logic       i_sync_locked,
	input  wire logic       i_rcvr_tracking,
	input  wire logic       i_rcvr_locked,
	input  wire logic       i_loop_locked,
	input  wire logic       i_loop_delay_lsb,
	// Phase loop configuration and loop lost flag
	output logic            o_loop_enable,
	output logic [1:0]      o_loop_mode,
	output logic            o_loop_slope,
	output logic            o_loop_readback,
	output logic [1:0]      o_loop_gain,
	output logic [1:0]      o_search_dir,
	output logic [4:0]      o_target_phase,
	output logic            o_delay_lsb,
	output logic            o_phase_det_en,
	output logic            o_cmp_boost,
	output logic            o_duty_en,
	output logic            o_loop_lost,
	// Clock input common mode
	output logic            o_pos_dir,
	output logic [3:0]      o_pos_mag,
	output logic            o_neg_dir,
	output logic [3:0]      o_neg_mag
);

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	logic       spi_wr;
	logic [6:0] spi_addr;
	logic [7:0] spi_wdata;
	logic [7:0] rdata;

	dpc_spi_port #(
		.ADDR_W (dpc_pkg::ADDR_W),
		.DATA_W (dpc_pkg::DATA_W)
	) u_spi (
		.i_mclk   (i_mclk),
		.i_rstn   (i_rstn),
		.i_sclk   (i_sclk),
		.i_csn    (i_csn),
		.i_sdi    (i_sdi),
		.o_sdo    (o_sdo),
		.o_sdo_oe (o_sdo_oe),
		.i_rdata  (rdata),
		.o_wr     (spi_wr),
		.o_addr   (spi_addr),
		.o_wdata  (spi_wdata)
	);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic [7:0] pos_q;
	logic [7:0] neg_q;
	logic [7:0] bias_q;
	logic [7:0] duty_q;
	logic [7:0] main_q;
	logic [7:0] srch_q;

	// status address has no write strobe
	wire wr_pos  = spi_wr & (spi_addr == dpc_pkg::ADDR_POS_CM);
	wire wr_neg  = spi_wr & (spi_addr == dpc_pkg::ADDR_NEG_CM);
	wire wr_bias = spi_wr & (spi_addr == dpc_pkg::ADDR_BIAS);
	wire wr_duty = spi_wr & (spi_addr == dpc_pkg::ADDR_DUTY);
	wire wr_main = spi_wr & (spi_addr == dpc_pkg::ADDR_MAIN);
	wire wr_srch = spi_wr & (spi_addr == dpc_pkg::ADDR_SRCH);

	// Loop restart clears its lost flag
	wire loop_start = wr_main & spi_wdata[dpc_pkg::MAIN_EN] & ~main_q[dpc_pkg::MAIN_EN];

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			pos_q  <= dpc_pkg::RST_ZERO;
			neg_q  <= dpc_pkg::RST_ZERO;
			bias_q <= dpc_pkg::RST_ZERO;
			duty_q <= dpc_pkg::RST_ZERO;
			main_q <= dpc_pkg::RST_MAIN;
			srch_q <= dpc_pkg::RST_ZERO;
		end else begin
			if (wr_pos) pos_q <= spi_wdata & dpc_pkg::MASK_CM;
			if (wr_neg) neg_q <= spi_wdata & dpc_pkg::MASK_CM;
			if (wr_bias) bias_q <= spi_wdata & dpc_pkg::MASK_BIAS;
			if (wr_duty) duty_q <= spi_wdata & dpc_pkg::MASK_DUTY;
			if (wr_main) main_q <= spi_wdata & dpc_pkg::MASK_MAIN;
			if (wr_srch) srch_q <= spi_wdata & dpc_pkg::MASK_SRCH;
		end
	end

	// ----------------------------------------------------------------
	// Lock loss tracking
	// ----------------------------------------------------------------
	function automatic logic lost_next(input logic lost, input logic prev,
	                                   input logic now, input logic clr);
		lost_next = (prev & ~now) | (lost & ~clr);
	endfunction

	logic sync_prev_q;
	logic rcvr_prev_q;
	logic loop_prev_q;
	logic sync_lost_q;
	logic rcvr_lost_q;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync_prev_q <= 1'b0;
			rcvr_prev_q <= 1'b0;
			loop_prev_q <= 1'b0;
			sync_lost_q <= 1'b0;
			rcvr_lost_q <= 1'b0;
			o_loop_lost <= 1'b0;
		end else begin
			sync_prev_q <= i_sync_locked;
			rcvr_prev_q <= i_rcvr_locked;
			loop_prev_q <= i_loop_locked;
			sync_lost_q <= lost_next(sync_lost_q, sync_prev_q, i_sync_locked, 1'b0);
			rcvr_lost_q <= lost_next(rcvr_lost_q, rcvr_prev_q, i_rcvr_locked, 1'b0);
			// loop lost, set beats restart clear
			o_loop_lost <= lost_next(o_loop_lost, loop_prev_q, i_loop_locked, loop_start);
		end
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	// tracking and lock bits
	wire [7:0] status_rd = {i_sync_tracking, 1'b0, sync_lost_q, i_sync_locked,
	                        i_rcvr_tracking, 1'b0, rcvr_lost_q, i_rcvr_locked};
	// locked delay value when readback and enable set
	wire       del_rd   = (main_q[dpc_pkg::MAIN_RD] & main_q[dpc_pkg::MAIN_EN]) ?
	                      i_loop_delay_lsb : srch_q[dpc_pkg::SRCH_DEL_LSB];
	wire [7:0] srch_rd  = {del_rd, srch_q[6:0]};
	wire [7:0] loop_rd  = {6'h00, o_loop_lost, i_loop_locked};

	assign rdata = (spi_addr == dpc_pkg::ADDR_STATUS)  ? status_rd :
	               (spi_addr == dpc_pkg::ADDR_POS_CM)  ? pos_q :
	               (spi_addr == dpc_pkg::ADDR_NEG_CM)  ? neg_q :
	               (spi_addr == dpc_pkg::ADDR_BIAS)    ? bias_q :
	               (spi_addr == dpc_pkg::ADDR_DUTY)    ? duty_q :
	               (spi_addr == dpc_pkg::ADDR_MAIN)    ? main_q :
	               (spi_addr == dpc_pkg::ADDR_SRCH)    ? srch_rd :
	               (spi_addr == dpc_pkg::ADDR_LOOP_ST) ? loop_rd : 8'h00;

	// ----------------------------------------------------------------
	// Configuration outputs
	// ----------------------------------------------------------------
	// enable
	assign o_loop_enable   = main_q[dpc_pkg::MAIN_EN];
	assign o_loop_mode     = main_q[dpc_pkg::MAIN_MODE_LO +: 2];
	assign o_loop_slope    = main_q[dpc_pkg::MAIN_SLOPE];
	assign o_loop_readback = main_q[dpc_pkg::MAIN_RD];
	assign o_loop_gain     = main_q[dpc_pkg::MAIN_GAIN_LO +: 2];
	assign o_search_dir    = srch_q[dpc_pkg::SRCH_DIR_LO +: 2];
	assign o_target_phase  = srch_q[4:0];
	assign o_delay_lsb     = srch_q[dpc_pkg::SRCH_DEL_LSB];
	assign o_phase_det_en  = bias_q[dpc_pkg::BIAS_PD];
	assign o_cmp_boost     = bias_q[dpc_pkg::BIAS_CMP];
	assign o_duty_en       = duty_q[dpc_pkg::DUTY_EN];
	assign o_pos_dir       = pos_q[dpc_pkg::CM_DIR];
	assign o_pos_mag       = pos_q[3:0];
	assign o_neg_dir       = neg_q[dpc_pkg::CM_DIR];
	assign o_neg_mag       = neg_q[3:0];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	sequence sync_drop_s;
		i_sync_locked ##1 !i_sync_locked;
	endsequence

	sequence main_write_s;
		wr_main ##1 1'b1;
	endsequence

	track_bits_a: assert property (
		spi_addr == dpc_pkg::ADDR_STATUS |->
		rdata[7] == i_sync_tracking && rdata[3] == i_rcvr_tracking)
		else $error("tracking bits wrong");
	lock_bits_a: assert property (
		spi_addr == dpc_pkg::ADDR_STATUS |->
		rdata[4] == i_sync_locked && rdata[0] == i_rcvr_locked)
		else $error("lock bits wrong");
	sync_lost_set_a: assert property (sync_drop_s |=> sync_lost_q [*3])
		else $error("sync lost flag not set and held");
	rcvr_lost_idle_a: assert property (
		!rcvr_lost_q && !$fell(i_rcvr_locked) |=> !rcvr_lost_q)
		else $error("receiver lost flag set without loss");
	enable_follow_a: assert property (
		main_write_s |-> o_loop_enable == $past(spi_wdata[0]))
		else $error("enable not taken from write");
	mode_follow_a: assert property (
		wr_main |=> o_loop_mode == $past(spi_wdata[5:4]) && o_loop_slope == $past(spi_wdata[6]))
		else $error("mode or slope not taken");
	readback_sel_a: assert property (
		spi_addr == dpc_pkg::ADDR_SRCH && o_loop_readback && o_loop_enable |->
		rdata[7] == i_loop_delay_lsb)
		else $error("delay readback wrong");
	gain_hold_a: assert property (!wr_main |=> $stable(o_loop_gain))
		else $error("gain changed without write");
	dir_follow_a: assert property (
		wr_srch |=> o_search_dir == $past(spi_wdata[6:5]) && o_target_phase == $past(spi_wdata[4:0]))
		else $error("search fields not taken");
	offset_follow_a: assert property (
		wr_pos |=> o_pos_mag == $past(spi_wdata[3:0]) && o_pos_dir == $past(spi_wdata[4]))
		else $error("offset fields not taken");
	loop_lost_set_a: assert property ($fell(i_loop_locked) |=> o_loop_lost)
		else $error("loop lost flag not set");

endmodule // dpc_regs

/* File: testbench/dpc_regs_tb_top.sv */
// Self-checking bench for the phase-loop control and lock status register bank
`timescale 1ns/1ps
module dpc_regs_tb_top;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic       i_mclk, i_rstn, i_sclk, i_csn, i_sdi, o_sdo, o_sdo_oe;
	logic       i_sync_tracking, i_sync_locked, i_rcvr_tracking, i_rcvr_locked;
	logic       i_loop_locked, i_loop_delay_lsb;
	logic       o_loop_enable, o_loop_slope, o_loop_readback, o_delay_lsb, o_loop_lost;
	logic       o_phase_det_en, o_cmp_boost, o_duty_en, o_pos_dir, o_neg_dir;
	logic [1:0] o_loop_mode, o_loop_gain, o_search_dir;
	logic [4:0] o_target_phase;
	logic [3:0] o_pos_mag, o_neg_mag;
	logic [7:0] rd_q;
	logic [7:0] oe_q;
	int         failures, checks_done, cycles;
	wire  [7:0] main_v = {o_loop_enable, o_loop_slope, o_loop_gain, o_loop_mode,
	                      o_loop_readback, o_loop_lost};
	wire  [7:0] srch_v = {o_delay_lsb, o_search_dir, o_target_phase};
	wire  [7:0] misc_v = {o_pos_dir, o_pos_mag, o_phase_det_en, o_cmp_boost, o_duty_en};
	wire  [7:0] neg_v  = {o_neg_dir, o_neg_mag, 3'h0};

	dpc_regs dut_u (.i_mclk, .i_rstn, .i_sclk, .i_csn, .i_sdi, .o_sdo, .o_sdo_oe,
		.i_sync_tracking, .i_sync_locked, .i_rcvr_tracking, .i_rcvr_locked,
		.i_loop_locked, .i_loop_delay_lsb, .o_loop_enable, .o_loop_mode, .o_loop_slope,
		.o_loop_readback, .o_loop_gain, .o_search_dir, .o_target_phase, .o_delay_lsb,
		.o_phase_det_en, .o_cmp_boost, .o_duty_en, .o_loop_lost, .o_pos_dir, .o_pos_mag,
		.o_neg_dir, .o_neg_mag);

	// ----------------------------------------------------------------
	// Clock and timeout
	// ----------------------------------------------------------------
	always #5 i_mclk = ~i_mclk;

	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One 16-bit frame, MSB first, sclk half period of 5 mclk
	task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] d);
		logic [15:0] sh;
		sh = {rw, a, d};
		i_csn = 1'b0;
		repeat (4) @(negedge i_mclk);
		for (int i = 15; i >= 0; i--) begin
			i_sdi = sh[i];
			repeat (5) @(negedge i_mclk);
			if (i < 8) begin
				rd_q[i] = o_sdo;
				oe_q[i] = o_sdo_oe;
			end
			i_sclk = 1'b1;
			repeat (5) @(negedge i_mclk);
			i_sclk = 1'b0;
		end
		repeat (5) @(negedge i_mclk);
		i_csn = 1'b1;
		repeat (8) @(negedge i_mclk);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		frame(1'b0, a, d);
		check("write drive", oe_q, 8'h00);
	endtask

	task automatic rd(input string what, input logic [6:0] a, input logic [7:0] exp);
		frame(1'b1, a, 8'h00);
		check(what, rd_q, exp);
		check("read drive", oe_q, 8'hFF);
		check("drive released", {7'h00, o_sdo_oe}, 8'h00);
	endtask

	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check("main outputs", main_v, 8'h50);
		check("search outputs", srch_v, 8'h00);
		check("misc outputs", misc_v, 8'h00);
		check("neg leg outputs", neg_v, 8'h00);
		for (int a = 8'h22; a <= 8'h27; a++)
			rd("reset value", a[6:0], (a == 8'h26) ? dpc_pkg::RST_MAIN : 8'h00);
	endtask

	task automatic t_clk_offset();
		wr(dpc_pkg::ADDR_POS_CM, 8'h1F);
		wr(dpc_pkg::ADDR_NEG_CM, 8'hEA);
		check("pos leg", misc_v, 8'hF8);
		check("neg leg", neg_v, 8'h50);
		rd("pos reg", dpc_pkg::ADDR_POS_CM, 8'h1F);
		rd("neg reg", dpc_pkg::ADDR_NEG_CM, 8'h0A);
		wr(dpc_pkg::ADDR_POS_CM, 8'h0F);
		wr(dpc_pkg::ADDR_NEG_CM, 8'h1F);
		check("pos leg down", misc_v, 8'h78);
		check("neg leg up", neg_v, 8'hF8);
	endtask

	task automatic t_bias();
		wr(dpc_pkg::ADDR_BIAS, 8'hFF);
		wr(dpc_pkg::ADDR_DUTY, 8'hFF);
		check("bias and duty", misc_v, 8'h7F);
		rd("bias reg", dpc_pkg::ADDR_BIAS, 8'h30);
		rd("duty reg", dpc_pkg::ADDR_DUTY, 8'h80);
	endtask

	task automatic t_main();
		for (int m = 0; m < 3; m++) begin
			wr(dpc_pkg::ADDR_MAIN, {2'b00, m[1:0], 4'hD});
			check("main fields", main_v, {4'hA, m[1:0], 2'b10});
			rd("main reg", dpc_pkg::ADDR_MAIN, {2'b00, m[1:0], 4'hD});
		end
		wr(dpc_pkg::ADDR_MAIN, 8'hC2);
		check("main disabled", main_v, 8'h50);
		rd("main reserved", dpc_pkg::ADDR_MAIN, 8'h42);
	endtask

	task automatic t_srch();
		for (int d = 0; d < 3; d++) begin
			wr(dpc_pkg::ADDR_SRCH, {d[0], d[1:0], 5'h10});
			check("search fields", srch_v, {d[0], d[1:0], 5'h10});
			rd("search reg", dpc_pkg::ADDR_SRCH, {d[0], d[1:0], 5'h10});
		end
	endtask

	task automatic t_status();
		rd("status idle", dpc_pkg::ADDR_STATUS, 8'h00);
		{i_sync_tracking, i_sync_locked, i_rcvr_tracking, i_rcvr_locked} = 4'hF;
		rd("status all on", dpc_pkg::ADDR_STATUS, 8'h99);
		i_sync_locked = 1'b0;
		rd("sync lost", dpc_pkg::ADDR_STATUS, 8'hA9);
		i_sync_locked = 1'b1;
		rd("sync lost sticky", dpc_pkg::ADDR_STATUS, 8'hB9);
		i_rcvr_locked = 1'b0;
		rd("rcvr lost", dpc_pkg::ADDR_STATUS, 8'hBA);
		wr(dpc_pkg::ADDR_STATUS, 8'h00);
		rd("status after write", dpc_pkg::ADDR_STATUS, 8'hBA);
	endtask

	task automatic t_loop();
		i_loop_locked = 1'b1;
		rd("loop locked", dpc_pkg::ADDR_LOOP_ST, 8'h01);
		i_loop_locked = 1'b0;
		rd("loop lost", dpc_pkg::ADDR_LOOP_ST, 8'h02);
		check("loop lost out", {7'h00, o_loop_lost}, 8'h01);
		wr(dpc_pkg::ADDR_SRCH, 8'h90);
		wr(dpc_pkg::ADDR_MAIN, 8'h4B);
		i_loop_delay_lsb = 1'b0;
		rd("live delay lsb", dpc_pkg::ADDR_SRCH, 8'h10);
		rd("loop lost cleared", dpc_pkg::ADDR_LOOP_ST, 8'h00);
		wr(dpc_pkg::ADDR_MAIN, 8'h43);
		rd("written delay lsb", dpc_pkg::ADDR_SRCH, 8'h90);
		wr(7'h30, 8'hFF);
		rd("unmapped", 7'h30, 8'h00);
	endtask

	task automatic t_rst_mid();
		i_rstn = 1'b0;
		repeat (2) @(negedge i_mclk);
		i_rstn = 1'b1;
		repeat (4) @(negedge i_mclk);
		check("main after reset", main_v, 8'h50);
		rd("lost cleared by reset", dpc_pkg::ADDR_STATUS, 8'h98);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{i_mclk, i_rstn, i_sclk, i_csn, i_sdi} = 5'b00010;
		{i_sync_tracking, i_sync_locked, i_rcvr_tracking, i_rcvr_locked} = 4'h0;
		{i_loop_locked, i_loop_delay_lsb} = 2'b01;
		{failures, checks_done, cycles} = '0;
		rd_q = 8'h00;
		repeat (12) @(negedge i_mclk);
		i_rstn = 1'b1;
		repeat (4) @(negedge i_mclk);
		t_reset();
		t_clk_offset();
		t_bias();
		t_main();
		t_srch();
		t_status();
		t_loop();
		t_rst_mid();
		results();
	end

endmodule // dpc_regs_tb_top
